//--- verilog/ccr_defs.svh
// constants for the conversion configuration register block
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH
`define CCR_CFG_ADDR 8'h0a
`define CCR_CFG_RESET 8'ha0
`define CCR_VTF_HI 7
`define CCR_VTF_LO 6
`define CCR_CAPF_HI 5
`define CCR_CAPF_LO 3
`define CCR_MODE_HI 2
`define CCR_MODE_LO 0
// conversion times in units of 0.1 ms
`define CCR_VT_T0 12'd201
`define CCR_VT_T1 12'd321
`define CCR_VT_T2 12'd621
`define CCR_VT_T3 12'd1221
`define CCR_CAP_T0 12'd110
`define CCR_CAP_T1 12'd119
`define CCR_CAP_T2 12'd200
`define CCR_CAP_T3 12'd380
`define CCR_CAP_T4 12'd620
// 0.1 ms at 50 MHz (20 ns period)
`define CCR_CLK_NS 20
`define CCR_TICK_NS 100000
`define CCR_TICK_CYC (`CCR_TICK_NS / `CCR_CLK_NS)
`endif

//--- verilog/ccr_pkg.sv
// types for the conversion configuration register block
`default_nettype none
package ccr_pkg;
  typedef enum logic [2:0] {
    CCR_MD_IDLE = 3'h0,
    CCR_MD_CONT = 3'h1,
    CCR_MD_SINGLE = 3'h2,
    CCR_MD_PDOWN = 3'h3,
    CCR_MD_UNUSED = 3'h4,
    CCR_MD_OFFCAL = 3'h5,
    CCR_MD_GAINCAL = 3'h6,
    CCR_MD_RSVD = 3'h7
  } ccr_mode_t;
  typedef struct packed {
    logic [1:0] vt_filter_sel;
    logic [2:0] cap_filter_sel;
    ccr_mode_t conv_mode_sel;
  } ccr_cfg_t;
  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccr_wr_t;
endpackage
`default_nettype wire

//--- verilog/ccr_timer.sv
// down counter of 0.1 ms ticks, reloaded on start
`timescale 1ns/10ps
`default_nettype none
module ccr_timer #(
  parameter int W = 13
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic tick,
  input wire logic start,
  input wire logic [W-1:0] load,
  // status
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_r;
  // counts ticks; done pulses as the count runs out
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= load;
        busy <= 1'b1;
      end else if (busy && tick) begin
        if (cnt_r <= W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_r <= cnt_r - W'(1);
      end
    end
  end
endmodule
`default_nettype wire

//--- verilog/ccr_top.sv
// conversion configuration register and conversion sequencer
//
// Notes on behaviour
// R1: the configuration register sits at pointer 0x0a and resets to 0xa0.
// R2: bits 7:6 pick the vt filter, bits 5:3 the cap filter, bits 2:0 the mode.
// R3: vt codes 00..11 give 20.1, 32.1, 62.1 and 122.1 ms with vt chopping on.
// R4: cap codes 000..100 give 11.0, 11.9, 20.0, 38.0 and 62.0 ms without cap chopping.
// R5: these times hold with clock halving off and are doubled with it on.
// R6: clock halving halves the excitation and modulator clock rates; only mod_clk_en is halved here, no excitation clock is made.
// R7: modes are idle, continuous, single, power-down, offset cal and gain cal; 100 unused.
// R8: each period is counted from a reload of the current selectors at its start.
`timescale 1ns/10ps
`default_nettype none
`include "ccr_defs.svh"
module ccr_top #(
  parameter int TICK_CYC = `CCR_TICK_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register access from the serial interface
  input wire ccr_pkg::ccr_wr_t wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  // settings from the excitation register
  input wire logic clock_halving_ctrl,
  input wire logic vt_chop_enable,
  input wire logic enable_a,
  // converter control
  output logic mod_clk_en,
  output logic vt_busy,
  output logic cap_busy,
  output logic conv_done,
  output logic powered_down,
  output logic cal_active,
  output ccr_pkg::ccr_cfg_t cfg_out
);
  import ccr_pkg::*;

  // ----------------------------------------
  // register
  // ----------------------------------------
  ccr_cfg_t cfg_r;
  ccr_cfg_t cfg_idle;
  logic mode_clr;
  wire sel_cfg = wr.wr_en && (wr.addr == `CCR_CFG_ADDR); // [R1]
  // same filters with the mode field back at idle
  assign cfg_idle = '{vt_filter_sel: cfg_r.vt_filter_sel,
                      cap_filter_sel: cfg_r.cap_filter_sel,
                      conv_mode_sel: CCR_MD_IDLE};
  // holds filter and mode fields; a one-shot run clears its own mode,
  // otherwise a single conversion would quietly restart forever
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_r <= ccr_cfg_t'(`CCR_CFG_RESET); // [R1]
    end else if (sel_cfg) begin
      cfg_r <= ccr_cfg_t'(wr.wdata); // [R2]
    end else if (mode_clr) begin
      cfg_r <= cfg_idle; // [R7]
    end
  end
  wire [7:0] rd_nxt = (rd_addr == `CCR_CFG_ADDR) ? 8'(cfg_r) : 8'h00;
  // read data registered for a flop-driven output
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_nxt;
    end
  end

  // ----------------------------------------
  // time base
  // ----------------------------------------
  logic [16:0] div_r;
  logic half_r;
  wire div_end = (div_r == 17'(TICK_CYC - 1));
  wire tick = div_end && (!clock_halving_ctrl || half_r); // [R5]
  // 0.1 ms tick, slowed by two when halving is on
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_r <= 17'h00000;
      half_r <= 1'b0;
    end else begin
      div_r <= div_end ? 17'h00000 : div_r + 17'h00001;
      if (div_end) begin
        half_r <= ~half_r;
      end
    end
  end
  logic mclk_tog_r;
  // modulator clock enable toggles at half rate under halving
  always_ff @(posedge mclk) begin
    if (rst) begin
      mclk_tog_r <= 1'b0;
      mod_clk_en <= 1'b0;
    end else begin
      mclk_tog_r <= ~mclk_tog_r;
      mod_clk_en <= !clock_halving_ctrl || mclk_tog_r; // [R6]
    end
  end

  // ----------------------------------------
  // conversion time lookup
  // ----------------------------------------
  logic [12:0] vt_load;
  logic [12:0] cap_load;
  logic [11:0] vt_base;
  logic [11:0] cap_base;
  // vt time assumes chopping on; cap time assumes chopping off
  always_comb begin
    case (cfg_r.vt_filter_sel)
      2'h0: vt_base = `CCR_VT_T0; // [R3]
      2'h1: vt_base = `CCR_VT_T1;
      2'h2: vt_base = `CCR_VT_T2;
      default: vt_base = `CCR_VT_T3;
    endcase
    case (cfg_r.cap_filter_sel)
      3'h0: cap_base = `CCR_CAP_T0; // [R4]
      3'h1: cap_base = `CCR_CAP_T1;
      3'h2: cap_base = `CCR_CAP_T2;
      3'h3: cap_base = `CCR_CAP_T3;
      default: cap_base = `CCR_CAP_T4; // codes above 100 not covered here
    endcase
    vt_load = {1'b0, vt_base};
    cap_load = {1'b0, cap_base};
  end
  wire chop_ok = vt_chop_enable && !enable_a; // tabled times valid only here

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_CAP, S_VT, S_PDOWN} ccr_seq_t;
  ccr_seq_t st_r;
  ccr_seq_t st_nxt;
  ccr_mode_t md;
  logic cap_start;
  logic vt_start;
  wire cap_done;
  wire vt_done;
  wire cap_run;
  wire vt_run;
  assign md = cfg_r.conv_mode_sel;
  wire md_conv = (md == CCR_MD_CONT) || (md == CCR_MD_SINGLE) ||
                 (md == CCR_MD_OFFCAL) || (md == CCR_MD_GAINCAL); // [R7]
  // picks the next phase; selectors are latched only at a start
  always_comb begin
    st_nxt = st_r;
    cap_start = 1'b0;
    vt_start = 1'b0;
    case (st_r)
      S_IDLE: begin
        if (md == CCR_MD_PDOWN) begin
          st_nxt = S_PDOWN;
        end else if (md_conv) begin
          st_nxt = S_CAP;
          cap_start = 1'b1; // [R8]
        end
      end
      S_CAP: begin
        if (cap_done) begin
          st_nxt = S_VT;
          vt_start = 1'b1; // [R8]
        end
      end
      S_VT: begin
        if (vt_done) begin
          st_nxt = S_IDLE;
        end
      end
      S_PDOWN: begin
        if (md != CCR_MD_PDOWN) begin
          st_nxt = S_IDLE;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end
  // a finished single or calibration run falls back to idle mode
  wire one_shot = (md != CCR_MD_CONT);
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= S_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign mode_clr = vt_done && one_shot && !sel_cfg; // host write wins
  logic [2:0] md_hold;
  assign md_hold = 3'(md);
  // ----------------------------------------
  // timers
  // ----------------------------------------
  ccr_timer #(.W(13)) u_cap (
    .mclk(mclk), .rst(rst), .tick(tick), .start(cap_start),
    .load(cap_load), .busy(cap_run), .done(cap_done)
  );
  ccr_timer #(.W(13)) u_vt (
    .mclk(mclk), .rst(rst), .tick(tick), .start(vt_start),
    .load(vt_load), .busy(vt_run), .done(vt_done)
  );

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      vt_busy <= 1'b0;
      cap_busy <= 1'b0;
      conv_done <= 1'b0;
      powered_down <= 1'b0;
      cal_active <= 1'b0;
      cfg_out <= ccr_cfg_t'(`CCR_CFG_RESET);
    end else begin
      vt_busy <= vt_run;
      cap_busy <= cap_run;
      conv_done <= vt_done && chop_ok;
      powered_down <= (st_r == S_PDOWN);
      cal_active <= md_hold[2] && (st_r != S_IDLE);
      cfg_out <= mode_clr ? cfg_idle : cfg_r;
    end
  end
endmodule
`default_nettype wire

//--- verif/ccr_host.sv
// host model driving the configuration register writes and reads
`timescale 1ns/10ps
`default_nettype none
module ccr_host import ccr_pkg::*; (
  // clock
  input wire logic mclk,
  // register access
  output var ccr_wr_t wr,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  initial begin
    wr = '0;
    rd_addr = 8'h00;
  end
  // one byte per write; a released bus shows no stale byte
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge mclk);
    wr <= '{1'b1, a, d};
    @(posedge mclk);
    wr <= '{1'b0, ~a, ~d};
  endtask
  // read data is registered, so it is taken one edge later
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    rd_addr <= a;
    repeat (2) @(posedge mclk);
    d = rd_data;
  endtask
endmodule
`default_nettype wire

//--- verif/ccr_top_properties.sv
// port checker for the configuration register block
`timescale 1ns/10ps
`default_nettype none
module ccr_chk import ccr_pkg::*; (
  // clock, reset, register access
  input wire logic mclk,
  input wire logic rst,
  input wire ccr_wr_t wr,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  // settings
  input wire logic clock_halving_ctrl,
  input wire logic vt_chop_enable,
  input wire logic enable_a,
  // converter control
  input wire logic mod_clk_en,
  input wire logic vt_busy,
  input wire logic cap_busy,
  input wire logic conv_done,
  input wire logic powered_down,
  input wire logic cal_active,
  input wire ccr_cfg_t cfg_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // idle-mode writes only, since a run end clears the mode field
  property p_wr;
    wr.wr_en && wr.addr == 8'h0a && wr.wdata[2:0] == 3'h0 ##1 !wr.wr_en
      |=> cfg_out == $past(wr.wdata, 2);
  endproperty
  property p_rd0; rd_addr != 8'h0a |=> rd_data == 8'h00; endproperty
  // the reset edge itself leaves the enable low, so start one edge later
  property p_full;
    !rst && !clock_halving_ctrl ##1 !clock_halving_ctrl |-> mod_clk_en;
  endproperty
  property p_half;
    !rst && clock_halving_ctrl ##1 clock_halving_ctrl [*2]
      |-> mod_clk_en != $past(mod_clk_en);
  endproperty
  property p_gate; conv_done |-> $past(vt_chop_enable) && !$past(enable_a); endproperty
  property p_pulse; conv_done |=> !conv_done; endproperty
  property p_pd; powered_down |-> !vt_busy && !cap_busy; endproperty
  property p_seq; $fell(cap_busy) |-> ##[0:3] vt_busy; endproperty
  a_wr: assert property (p_wr) else $error("cfg_out differs from write");
  a_rd0: assert property (p_rd0) else $error("unmapped read nonzero");
  a_full: assert property (p_full) else $error("clock gated without halving");
  a_half: assert property (p_half) else $error("clock not halved");
  a_gate: assert property (p_gate) else $error("done outside chop setting");
  a_pulse: assert property (p_pulse) else $error("done longer than a cycle");
  a_pd: assert property (p_pd) else $error("busy in power-down");
  a_seq: assert property (p_seq) else $error("vt phase missing");
  c_done: cover property (conv_done);
  c_pd: cover property (powered_down);
  c_cal: cover property (cal_active);
endmodule
bind ccr_top ccr_chk chk_u (
  .mclk(mclk), .rst(rst), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
  .clock_halving_ctrl(clock_halving_ctrl), .vt_chop_enable(vt_chop_enable),
  .enable_a(enable_a), .mod_clk_en(mod_clk_en), .vt_busy(vt_busy),
  .cap_busy(cap_busy), .conv_done(conv_done), .powered_down(powered_down),
  .cal_active(cal_active), .cfg_out(cfg_out)
);
`default_nettype wire

//--- verif/conversion_rate_mode_config_tb.sv
// self-checking bench for the configuration register block
`timescale 1ns/10ps
`default_nettype none
module conversion_rate_mode_config_tb;
  import ccr_pkg::*;
  logic mclk = 0, rst = 1, clock_halving_ctrl = 0, vt_chop_enable = 1, enable_a = 0;
  ccr_wr_t wr;
  logic [7:0] rd_addr, rd_data, d, q;
  logic mod_clk_en, vt_busy, cap_busy, conv_done, powered_down, cal_active;
  ccr_cfg_t cfg_out;
  int fails = 0, n_checks = 0, cyc = 0, e;
  integer seed = 6154;
  logic [2:0] md_t[3] = '{3'h2, 3'h5, 3'h6};
  logic [2:0] lp_t[4] = '{3'h0, 3'h3, 3'h4, 3'h7};
  int exp_q[$];
  int vt_t[4] = '{201, 321, 621, 1221};
  int cap_t[5] = '{110, 119, 200, 380, 620};
  // tick cut to 5 cycles so the long conversions stay short
  ccr_top #(.TICK_CYC(5)) dut_u (
    .mclk(mclk), .rst(rst), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
    .clock_halving_ctrl(clock_halving_ctrl), .vt_chop_enable(vt_chop_enable),
    .enable_a(enable_a), .mod_clk_en(mod_clk_en), .vt_busy(vt_busy),
    .cap_busy(cap_busy), .conv_done(conv_done), .powered_down(powered_down),
    .cal_active(cal_active), .cfg_out(cfg_out)
  );
  ccr_host host_u (.mclk(mclk), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data));
  always #10 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  task automatic cmp(input string n, input int x, s, input bit ok);
    n_checks++;
    if (!ok) begin
      fails++;
      $display("wrong value %s expected %0d seen %0d", n, x, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one run from idle; its end cycle is noted for the watcher unless enable_a is set
  task automatic run(input int v, c, input logic [2:0] m, input bit h);
    int t;
    t = (vt_t[v] + cap_t[c]) * (h ? 10 : 5);
    @(posedge mclk);
    clock_halving_ctrl <= h;
    host_u.wr_reg(8'h0a, {v[1:0], c[2:0], 3'h0});
    host_u.wr_reg(8'h0a, {v[1:0], c[2:0], m});
    if (!enable_a) exp_q.push_back(cyc + t);
    // continuous mode goes round again straight away
    if (!enable_a && m == 3'h1) exp_q.push_back(cyc + 2 * t);
    repeat (t / 2) @(posedge mclk);
    cmp("cal_active", m[2], cal_active, cal_active === m[2]);
    cmp("busy", 1, cap_busy | vt_busy, (cap_busy | vt_busy) === 1'b1);
    if (m == 3'h1) begin
      repeat (t) @(posedge mclk);
      host_u.wr_reg(8'h0a, {v[1:0], c[2:0], 3'h0});
    end
    repeat (t / 2 + 40) @(posedge mclk);
    cmp("missing conv_done", 0, exp_q.size(), exp_q.size() == 0);
  endtask
  // tick phase may cost a tick per timer, hence the slack
  always @(posedge mclk) begin
    if (!rst && conv_done) begin
      if (exp_q.size() == 0) cmp("spare conv_done", 0, 1, 0);
      else begin
        e = exp_q.pop_front();
        cmp("end cycle", e, cyc, (cyc - e) <= 24 && (e - cyc) <= 24);
      end
    end
  end
  // the runs take about 35k cycles
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 0;
    host_u.rd_reg(8'h0a, q);
    cmp("reset value", 8'ha0, q, q === 8'ha0);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      d[2:0] = lp_t[i];
      host_u.wr_reg(8'h0a, d);
      host_u.wr_reg(8'h0b, ~d);
      host_u.rd_reg(8'h0a, q);
      cmp("config", d, q, q === d && cfg_out === d);
      host_u.rd_reg(8'h0b, q);
      cmp("unmapped", 0, q, q === 8'h00);
      cmp("powered_down", 0, 0, powered_down === (d[2:0] == 3'h3));
    end
    $display("test register access done");
    for (int i = 0; i < 5; i++) run(i % 4, i, md_t[i % 3], i[0]);
    run(0, 0, 3'h1, 0);
    enable_a <= 1;
    run(0, 0, 3'h2, 0);
    $display("test conversion times done");
    test_done;
  end
endmodule
`default_nettype wire
